// File: rtl/pcicfg_header.sv
// PCI type 0 configuration header with command register gating.
// Assumes the PCI target decoder supplies cfg, io and memory strobes.
//
// Contract
// - Sixteen dword type 0 configuration header.
// - All-zero command: only configuration accesses answered, no mastering.
// - Command bits 3, 5, 7, 9 read zero, ignore writes.
// - Bit 0 writable, resets zero, gates I/O claims.
// - Bit 1 writable, resets zero, gates memory claims.
// - Bit 2 writable, resets zero, gates bus master requests.
// - Bit 4 writable, resets zero, gates write-and-invalidate use.
// - Bit 6 writable, resets zero, gates parity error response.
// - Parity response bit cleared while PCI reset asserted.
// - Bit 8 writable, resets zero, enables system error driver.
// - Address parity errors reported only with system error and parity response enabled.
// - Command bits 10 to 15 read zero; software writes zero.
// - As master, moves transmit and receive data to memory.
// - As target, host reaches the control registers.
// - BARs at 10h memory, 14h I/O, 18h flash.
// - CardBus information pointer unimplemented.
// - Capabilities bit set only with power option; pointer follows.
`timescale 1ns/1ps
module pcicfg_header
  import pcicfg_pkg::*;
#(
  parameter logic [15:0] VENDOR_IDENTIFIER = 16'h1234, // arbitrary value
  parameter logic [15:0] DEVICE_IDENTIFIER = 16'h5678, // arbitrary value
  parameter logic [7:0] REVISION = 8'h01, // arbitrary value
  parameter logic [23:0] CLASS_CODE = 24'h020000,
  parameter logic [15:0] SUBSYS_VENDOR = 16'h0000, // arbitrary value
  parameter logic [15:0] SUBSYS_ID = 16'h0000, // arbitrary value
  parameter logic [7:0] MIN_GRANT = 8'h08,
  parameter logic [7:0] MAX_LATENCY = 8'h18,
  parameter logic [7:0] CAP_OFFSET = 8'hDC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Configuration access
  input wire logic cfg_wr_in,
  input wire logic cfg_rd_in,
  input wire logic [5:0] cfg_addr_in,
  input wire logic [31:0] cfg_wdata_in,
  input wire logic [3:0] cfg_be_in,
  output logic [31:0] cfg_rdata_out,
  output logic cfg_rvalid_out,
  // Strap from external configuration memory
  input wire logic power_mgmt_option_bit_in,
  // Target decode
  input wire logic io_access_in,
  input wire logic mem_access_in,
  input wire logic [31:0] tgt_addr_in,
  output logic io_claim_out,
  output logic mem_claim_out,
  output logic flash_claim_out,
  output logic control_regs_sel_out,
  // Master side
  input wire logic master_req_in,
  input wire logic mwi_req_in,
  output logic master_req_out,
  output logic mwi_allowed_out,
  // Parity and system error
  input wire logic data_perr_in,
  input wire logic addr_perr_in,
  input wire logic master_op_in,
  output logic perr_assert_out,
  output logic serr_n_out,
  output logic serr_oe_out,
  // Command state
  output logic [15:0] command_out
);
  // ==========================================================
  // State
  // ==========================================================
  typedef struct packed {
    logic [15:0] cmd;
    logic perr_det;
    logic sig_serr;
    logic [7:0] cache_line;
    logic [7:0] latency;
    logic [31:0] mem_bar;
    logic [31:0] io_bar;
    logic [31:0] flash_bar;
    logic [31:0] rom_bar;
    logic [7:0] int_line;
    logic [31:0] rdata;
    logic rvalid;
    logic serr_drv;
  } pcicfg_state_type;

  pcicfg_state_type state_r;
  pcicfg_state_type state_nxt;
  logic [15:0] status_w;

  // Byte-enable merge of a write into a masked field
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be,
                                        input logic [31:0] mask);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res & mask;
  endfunction

  // BAR window compare
  function automatic logic bar_hit(input logic [31:0] bar,
                                   input logic [31:0] addr,
                                   input logic [31:0] mask);
    return ((bar ^ addr) & mask) == RESET_WORD;
  endfunction

  // ==========================================================
  // Status word
  // ==========================================================
  always_comb begin
    status_w = STATUS_FIXED;
    status_w[STATUS_CAP] = power_mgmt_option_bit_in;
    status_w[STATUS_PERR_DET] = state_r.perr_det;
    status_w[14] = state_r.sig_serr;
  end

  // ==========================================================
  // Next state
  // ==========================================================
  always_comb begin
    state_nxt = state_r;
    state_nxt.rvalid = cfg_rd_in;
    state_nxt.serr_drv = 1'b0;
    // Configuration accesses are served whatever the command
    if (cfg_wr_in) begin
      if (cfg_addr_in == OFS_CMD_STATUS) begin
        state_nxt.cmd = 16'(merge({16'h0000, state_r.cmd}, cfg_wdata_in,
          cfg_be_in, {16'h0000, CMD_WMASK}));
        if (cfg_be_in[3] && cfg_wdata_in[16 + STATUS_PERR_DET]) begin
          state_nxt.perr_det = 1'b0;
        end
        if (cfg_be_in[3] && cfg_wdata_in[30]) begin
          state_nxt.sig_serr = 1'b0;
        end
      end else if (cfg_addr_in == OFS_CACHE_LAT) begin
        state_nxt.cache_line = cfg_be_in[0] ? cfg_wdata_in[7:0]
                                            : state_r.cache_line;
        state_nxt.latency = cfg_be_in[1] ? cfg_wdata_in[15:8]
                                         : state_r.latency;
      end else if (cfg_addr_in == OFS_MEM_BAR) begin
        state_nxt.mem_bar = merge(state_r.mem_bar, cfg_wdata_in,
          cfg_be_in, MEM_BAR_MASK);
      end else if (cfg_addr_in == OFS_IO_BAR) begin
        state_nxt.io_bar = merge(state_r.io_bar, cfg_wdata_in,
          cfg_be_in, IO_BAR_MASK);
      end else if (cfg_addr_in == OFS_FLASH_BAR) begin
        state_nxt.flash_bar = merge(state_r.flash_bar, cfg_wdata_in,
          cfg_be_in, FLASH_BAR_MASK);
      end else if (cfg_addr_in == OFS_ROM_BAR) begin
        state_nxt.rom_bar = merge(state_r.rom_bar, cfg_wdata_in,
          cfg_be_in, ROM_BAR_MASK);
      end else if (cfg_addr_in == OFS_INTR) begin
        state_nxt.int_line = cfg_be_in[0] ? cfg_wdata_in[7:0]
                                          : state_r.int_line;
      end
      // Other locations drop the write
    end
    // Master data parity errors recorded only with response on
    if (data_perr_in && master_op_in && state_r.cmd[CMD_PERR]) begin
      state_nxt.perr_det = 1'b1;
    end
    // Address parity reported only with both enables set
    if (addr_perr_in && state_r.cmd[CMD_SERR] &&
        state_r.cmd[CMD_PERR]) begin
      state_nxt.sig_serr = 1'b1;
      state_nxt.serr_drv = 1'b1;
    end
    // Read data mux
    state_nxt.rdata = RESET_WORD;
    if (cfg_rd_in) begin
      if (cfg_addr_in == OFS_ID) begin
        state_nxt.rdata = {DEVICE_IDENTIFIER, VENDOR_IDENTIFIER};
      end else if (cfg_addr_in == OFS_CMD_STATUS) begin
        state_nxt.rdata = {status_w, state_r.cmd};
      end else if (cfg_addr_in == OFS_CLASS_REV) begin
        state_nxt.rdata = {CLASS_CODE, REVISION};
      end else if (cfg_addr_in == OFS_CACHE_LAT) begin
        state_nxt.rdata = {RESET_BYTE, HEADER_TYPE0, state_r.latency,
                           state_r.cache_line};
      end else if (cfg_addr_in == OFS_MEM_BAR) begin
        state_nxt.rdata = state_r.mem_bar;
      end else if (cfg_addr_in == OFS_IO_BAR) begin
        state_nxt.rdata = state_r.io_bar | IO_BAR_TYPE;
      end else if (cfg_addr_in == OFS_FLASH_BAR) begin
        state_nxt.rdata = state_r.flash_bar;
      end else if (cfg_addr_in == OFS_SUBSYS) begin
        state_nxt.rdata = {SUBSYS_ID, SUBSYS_VENDOR};
      end else if (cfg_addr_in == OFS_ROM_BAR) begin
        state_nxt.rdata = state_r.rom_bar;
      end else if (cfg_addr_in == OFS_CAP_PTR) begin
        state_nxt.rdata = {24'h000000, power_mgmt_option_bit_in ?
                           CAP_OFFSET : RESET_BYTE};
      end else if (cfg_addr_in == OFS_INTR) begin
        state_nxt.rdata = {MAX_LATENCY, MIN_GRANT, INT_PIN_A,
                           state_r.int_line};
      end
      // Cardbus pointer and reserved dwords read zero
    end
  end

  // ==========================================================
  // Registers
  // ==========================================================
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_r.cmd <= CMD_RESET;
      state_r.perr_det <= 1'b0;
      state_r.sig_serr <= 1'b0;
      state_r.cache_line <= RESET_BYTE;
      state_r.latency <= RESET_BYTE;
      state_r.mem_bar <= RESET_WORD;
      state_r.io_bar <= RESET_WORD;
      state_r.flash_bar <= RESET_WORD;
      state_r.rom_bar <= RESET_WORD;
      state_r.int_line <= RESET_BYTE;
      state_r.rdata <= RESET_WORD;
      state_r.rvalid <= 1'b0;
      state_r.serr_drv <= 1'b0;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ==========================================================
  // Target and master gating
  // ==========================================================
  always_comb begin
    io_claim_out = io_access_in && state_r.cmd[CMD_IO] &&
      bar_hit(state_r.io_bar, tgt_addr_in, IO_BAR_MASK);
    mem_claim_out = mem_access_in && state_r.cmd[CMD_MEM] &&
      bar_hit(state_r.mem_bar, tgt_addr_in, MEM_BAR_MASK);
    flash_claim_out = mem_access_in && state_r.cmd[CMD_MEM] &&
      bar_hit(state_r.flash_bar, tgt_addr_in, FLASH_BAR_MASK);
    control_regs_sel_out = io_claim_out || mem_claim_out;
    master_req_out = master_req_in && state_r.cmd[CMD_MASTER];
    mwi_allowed_out = mwi_req_in && state_r.cmd[CMD_MASTER] &&
      state_r.cmd[CMD_MWI];
    perr_assert_out = data_perr_in && state_r.cmd[CMD_PERR];
    serr_oe_out = state_r.serr_drv && state_r.cmd[CMD_SERR];
    serr_n_out = ~serr_oe_out;
  end

  assign cfg_rdata_out = state_r.rdata;
  assign cfg_rvalid_out = state_r.rvalid;
  assign command_out = state_r.cmd;
endmodule // pcicfg_header

// File: rtl/pcicfg_pkg.sv
// Constants for the PCI configuration header block.
// Assumes a 32-bit configuration access port addressed by byte offset.
package pcicfg_pkg;
  // ==========================================================
  // Header layout
  // ==========================================================
  localparam int PCICFG_DWORDS = 16;
  localparam logic [5:0] OFS_ID = 6'h00;
  localparam logic [5:0] OFS_CMD_STATUS = 6'h04;
  localparam logic [5:0] OFS_CLASS_REV = 6'h08;
  localparam logic [5:0] OFS_CACHE_LAT = 6'h0C;
  localparam logic [5:0] OFS_MEM_BAR = 6'h10;
  localparam logic [5:0] OFS_IO_BAR = 6'h14;
  localparam logic [5:0] OFS_FLASH_BAR = 6'h18;
  localparam logic [5:0] OFS_CARDBUS = 6'h28;
  localparam logic [5:0] OFS_SUBSYS = 6'h2C;
  localparam logic [5:0] OFS_ROM_BAR = 6'h30;
  localparam logic [5:0] OFS_CAP_PTR = 6'h34;
  localparam logic [5:0] OFS_INTR = 6'h3C;
  // ==========================================================
  // Command field positions
  // ==========================================================
  localparam int CMD_IO = 0;
  localparam int CMD_MEM = 1;
  localparam int CMD_MASTER = 2;
  localparam int CMD_MWI = 4;
  localparam int CMD_PERR = 6;
  localparam int CMD_SERR = 8;
  localparam logic [15:0] CMD_WMASK = 16'h0157;
  localparam logic [15:0] CMD_RESET = 16'h0000;
  // ==========================================================
  // Status constants
  // ==========================================================
  localparam logic [15:0] STATUS_FIXED = 16'h0280;
  localparam int STATUS_CAP = 4;
  localparam int STATUS_PERR_DET = 8;
  // ==========================================================
  // BAR sizing masks and types
  // ==========================================================
  localparam logic [31:0] MEM_BAR_MASK = 32'hFFFFF000;
  localparam logic [31:0] IO_BAR_MASK = 32'hFFFFFFE0;
  localparam logic [31:0] FLASH_BAR_MASK = 32'hFFF00000;
  localparam logic [31:0] ROM_BAR_MASK = 32'hFFF00001;
  localparam logic [31:0] IO_BAR_TYPE = 32'h00000001;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [31:0] RESET_WORD = 32'h00000000;
  localparam logic [7:0] HEADER_TYPE0 = 8'h00;
  localparam logic [7:0] INT_PIN_A = 8'h01;
endpackage

// File: verification/pcicfg_header_sva.sv
// Port checker for the configuration header.
// Assumes one clock and a synchronous high reset.
`timescale 1ns/1ps
module pcicfg_header_sva (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // Watched ports
  input wire logic cfg_rd_in,
  input wire logic cfg_rvalid_out,
  input wire logic [15:0] command_out,
  input wire logic io_claim_out,
  input wire logic mem_claim_out,
  input wire logic master_req_in,
  input wire logic master_req_out,
  input wire logic mwi_allowed_out,
  input wire logic data_perr_in,
  input wire logic perr_assert_out,
  input wire logic addr_perr_in,
  input wire logic serr_oe_out,
  input wire logic serr_n_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  chk_cmd_fixed_zero: assert property (
    (command_out & 16'hFEA8) == 16'h0000) else $error("fixed bits set");
  chk_reset_clears: assert property (
    $fell(rst_in) |-> command_out == 16'h0000) else $error("no reset");
  chk_read_answer: assert property (
    cfg_rd_in |=> cfg_rvalid_out) else $error("read not answered");
  chk_io_gate: assert property (
    io_claim_out |-> command_out[0]) else $error("io claim gated off");
  chk_mem_gate: assert property (
    mem_claim_out |-> command_out[1]) else $error("mem claim gated off");
  chk_master_gate: assert property (
    master_req_out == (master_req_in && command_out[2]))
    else $error("master request gate");
  chk_mwi_gate: assert property (
    mwi_allowed_out |-> command_out[4] && command_out[2])
    else $error("mwi gate");
  chk_perr_gate: assert property (
    perr_assert_out == (data_perr_in && command_out[6]))
    else $error("parity response gate");
  chk_serr_cause: assert property (
    serr_oe_out |-> $past(addr_perr_in) && $past(command_out[8]))
    else $error("serr without cause");
  chk_serr_level: assert property (
    serr_n_out != serr_oe_out) else $error("serr level");
endmodule // pcicfg_header_sva

// File: verification/pcicfg_host.sv
// Host bridge model issuing configuration cycles.
// Assumes strobes are taken on the rising clock edge.
`timescale 1ns/1ps
module pcicfg_host (
  // Clock
  input wire logic clk_in,
  // Answer
  input wire logic [31:0] cfg_rdata_in,
  input wire logic cfg_rvalid_in,
  // Request
  output logic cfg_wr_out = 1'b0,
  output logic cfg_rd_out = 1'b0,
  output logic [5:0] cfg_addr_out = 6'h00,
  output logic [31:0] cfg_wdata_out = 32'h00000000,
  output logic [3:0] cfg_be_out = 4'h0
);
  task automatic cfg_write(input logic [5:0] a, input logic [31:0] d,
                           input logic [3:0] b);
    @(negedge clk_in);
    cfg_addr_out = a;
    cfg_wdata_out = d;
    cfg_be_out = b;
    cfg_wr_out = 1'b1;
    @(negedge clk_in);
    cfg_wr_out = 1'b0;
    // Released bus shows no stale value
    cfg_wdata_out = ~d;
    cfg_be_out = ~b;
  endtask
  task automatic cfg_read(input logic [5:0] a, output logic [31:0] d);
    @(negedge clk_in);
    cfg_addr_out = a;
    cfg_rd_out = 1'b1;
    @(negedge clk_in);
    cfg_rd_out = 1'b0;
    d = cfg_rvalid_in ? cfg_rdata_in : {32{1'bx}};
  endtask
endmodule // pcicfg_host

// File: verification/test_pcicfg_header.sv
// Self-checking bench for the configuration header.
// Assumes the host model drives every configuration cycle.
`timescale 1ns/1ps
module test_pcicfg_header;
  import pcicfg_pkg::*;
  logic clk_in = 1'b0, rst_in = 1'b1, power_mgmt_option_bit_in = 1'b0;
  logic io_access_in = 1'b0, mem_access_in = 1'b0, master_req_in = 1'b0;
  logic mwi_req_in = 1'b0, data_perr_in = 1'b0, addr_perr_in = 1'b0;
  logic master_op_in = 1'b0;
  logic [31:0] tgt_addr_in = 32'h00000000;
  logic cfg_wr_in, cfg_rd_in, cfg_rvalid_out, io_claim_out, mem_claim_out;
  logic flash_claim_out, control_regs_sel_out, master_req_out;
  logic mwi_allowed_out, perr_assert_out, serr_n_out, serr_oe_out;
  logic [5:0] cfg_addr_in;
  logic [31:0] cfg_wdata_in, cfg_rdata_out, d;
  logic [3:0] cfg_be_in;
  logic [15:0] command_out;
  int n_errors = 0;
  int comparisons = 0;
  always #2 clk_in = ~clk_in;
  pcicfg_header dut (.*);
  pcicfg_host host (.clk_in(clk_in), .cfg_rdata_in(cfg_rdata_out),
    .cfg_rvalid_in(cfg_rvalid_out), .cfg_wr_out(cfg_wr_in),
    .cfg_rd_out(cfg_rd_in), .cfg_addr_out(cfg_addr_in),
    .cfg_wdata_out(cfg_wdata_in), .cfg_be_out(cfg_be_in));
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude;
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ==========================================================
  // Scenarios
  // ==========================================================
  task automatic t_reset_values;
    host.cfg_read(6'h04, d);
    check(d, 32'h02800000);
    {io_access_in, mem_access_in, master_req_in} = 3'b111;
    {mwi_req_in, data_perr_in, addr_perr_in} = 3'b111;
    @(negedge clk_in);
    check({io_claim_out, mem_claim_out, master_req_out, mwi_allowed_out,
      perr_assert_out, serr_oe_out, serr_n_out}, 32'h01);
  endtask
  task automatic t_command_bits;
    host.cfg_write(6'h04, 32'hFFFFFFFF, 4'h3);
    check(command_out, 32'h0157);
    check({master_req_out, mwi_allowed_out, perr_assert_out}, 32'h7);
    @(negedge clk_in);
    check({serr_oe_out, serr_n_out}, 32'h2);
    host.cfg_write(6'h04, 32'h00000004, 4'h3);
    check({master_req_out, mwi_allowed_out}, 32'h2);
    addr_perr_in = 1'b0;
    host.cfg_write(6'h04, 32'h00000000, 4'h3);
    check({master_req_out, serr_oe_out, serr_n_out}, 32'h1);
  endtask
  task automatic t_decode;
    host.cfg_write(6'h10, 32'h20000000, 4'hF);
    host.cfg_write(6'h14, 32'h00001000, 4'hF);
    host.cfg_write(6'h04, 32'h00000003, 4'h3);
    {tgt_addr_in, io_access_in} = {32'h20000010, 1'b0};
    #1 check(mem_claim_out, 32'h1);
    check({flash_claim_out, control_regs_sel_out}, 32'h1);
    {tgt_addr_in, io_access_in, mem_access_in} = {32'h00001004, 2'b10};
    #1 check(io_claim_out, 32'h1);
    check({flash_claim_out, control_regs_sel_out}, 32'h1);
    host.cfg_write(6'h04, 32'h00000000, 4'h3);
    check(io_claim_out, 32'h0);
    host.cfg_write(6'h14, 32'hFFFFFFFF, 4'hF);
    host.cfg_read(6'h14, d);
    check(d, 32'hFFFFFFE1);
    host.cfg_write(6'h18, 32'hFFFFFFFF, 4'hF);
    host.cfg_read(6'h18, d);
    check(d, 32'hFFF00000);
    host.cfg_write(6'h04, 32'h00000002, 4'h3);
    {tgt_addr_in, mem_access_in} = {32'hFFF00010, 1'b1};
    #1 check({flash_claim_out, control_regs_sel_out}, 32'h2);
  endtask
  task automatic t_reserved;
    host.cfg_write(6'h20, 32'hFFFFFFFF, 4'hF);
    host.cfg_read(6'h20, d);
    check(d, 32'h00000000);
    host.cfg_read(6'h28, d);
    check(d, 32'h00000000);
    host.cfg_write(6'h3C, 32'hFFFFFFFF, 4'hF);
    host.cfg_read(6'h3C, d);
    check(d, 32'h180801FF);
    host.cfg_write(6'h0C, 32'hFFFFFFFF, 4'hF);
    host.cfg_read(6'h0C, d);
    check(d, 32'h0000FFFF);
  endtask
  task automatic t_capability;
    power_mgmt_option_bit_in = 1'b1;
    host.cfg_read(6'h04, d);
    check(d[20], 32'h1);
    check(d[30], 32'h1);
    host.cfg_write(6'h04, 32'h40000000, 4'h8);
    host.cfg_read(6'h04, d);
    check(d, 32'h02900002);
    host.cfg_read(6'h34, d);
    check(d, 32'h000000DC);
  endtask
  task automatic t_mid_reset;
    host.cfg_write(6'h04, 32'h00000040, 4'h3);
    check(command_out, 32'h0040);
    rst_in = 1'b1;
    @(negedge clk_in);
    rst_in = 1'b0;
    check(command_out, 32'h0000);
  endtask
  initial begin
    repeat (16) @(posedge clk_in);
    @(negedge clk_in);
    rst_in = 1'b0;
    t_reset_values();
    t_command_bits();
    t_decode();
    t_reserved();
    t_capability();
    t_mid_reset();
    conclude();
  end
  initial begin
    #20000;
    n_errors++;
    conclude();
  end
endmodule // test_pcicfg_header
bind pcicfg_header pcicfg_header_sva u_sva (.*);
